// ==== csc_conv_ctrl.sv ====
// Conversion sequencing for a two-channel converter: chop, sync, standby.
// Assumes filter results arrive on the reference clock from local logic.
//
// How it works
// - Chop enable cancels offset by pairing opposite-polarity conversions.
// - Polarity alternates; each output averages the latest two conversions.
// - Each swap resets the filter; three conversion periods then settle.
// - After each swap, wait a programmable settling delay of 2..65536.
// - Steady chop period equals settling delay plus three times ratio.
// - Each new chop result drives a falling edge on ready pin.
// - With chop on, sync pin fall or ratio change restarts all channels at once.
// - First chop result after restart takes two sequences plus 44.
// - The test signal is refused while chop is enabled.
// - Three power levels selected by a 2-bit field.
// - Standby command disables channels and powers down non-essentials.
// - Wakeup command leaves standby and resumes conversion.
// - Without chop, sync fall aligned with data timing does nothing, else realigns.
// - Peripheral only, mode 1: launch on rise, sample on fall.
// - Deselected: ignore serial activity, float output, reset interface.
// - Serial interface is full duplex within one frame.
// - Sync pin held low past threshold resets until it returns high.
`timescale 1ns/1ps
module csc_conv_ctrl #(
   parameter int OSR_W   = 15,
   parameter int RSL_CYC = csc_pkg::RSL_CYC
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_sys_rst,
   input  wire logic                      i_chop_enable_bit,
   input  wire logic [3:0]                i_chop_settle_delay_field,
   input  wire logic [OSR_W-1:0]          i_oversampling_ratio,
   input  wire logic [1:0]                i_power_level_field,
   input  wire logic                      i_test_signal_req,
   input  wire csc_pkg::csc_chan_pair_t   i_filt_data,
   input  wire logic [csc_pkg::CMD_W-1:0] i_status_word,
   input  wire logic                      i_sync_rst_n,
   input  wire logic                      i_cs_n,
   input  wire logic                      i_sclk,
   input  wire logic                      i_din,
   output logic                           o_dout,
   output logic                           o_dout_oe,
   output logic                           o_conversion_ready_pin_n,
   output csc_pkg::csc_chan_pair_t        o_result,
   output logic                           o_chop_polarity,
   output logic                           o_filter_rst,
   output logic                           o_mod_tick,
   output logic [1:0]                     o_power_level,
   output logic                           o_test_signal_en,
   output logic                           o_standby,
   output logic                           o_channels_on,
   output logic                           o_in_reset
);
   import csc_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   csc_state_t          state;
   csc_state_t          next_state;
   csc_spi_evt_t        spi_evt;
   csc_chan_pair_t      prev;
   csc_chan_pair_t      avg;
   logic [3:0]          div_cnt;
   logic [CNT_W-1:0]    tick_cnt;
   logic [OSR_W-1:0]    osr_q;
   logic [2:0]          sy_pin;
   logic [31:0]         low_cnt;
   logic                have_first;
   logic                conversion_ready_pin_pend;
   logic                spi_dout;
   logic                spi_oe;

   // ------------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------------
   // Level to divider
   wire [3:0] div_len =
      (i_power_level_field == LOW_POWER_LEVEL)      ? MOD_DIV_LP  :
      (i_power_level_field == VERY_LOW_POWER_LEVEL) ? MOD_DIV_VLP :
                                                      MOD_DIV_HR;
   wire mod_tick = (div_cnt == div_len - 4'h1);

   wire [CNT_W-1:0] settle_len =
      CNT_W'(18'h00001 << ({1'b0, i_chop_settle_delay_field} + 5'h01));
   wire [CNT_W-1:0] conv_chop = CNT_W'(CONV_MULT) * CNT_W'(i_oversampling_ratio);
   wire [CNT_W-1:0] conv_len  =
      i_chop_enable_bit ? conv_chop : CNT_W'(i_oversampling_ratio);
   wire [CNT_W-1:0] lead_len  = CNT_W'(LEAD_TICKS);

   wire sy_low   = ~sy_pin[1];
   wire sy_fall  = sy_pin[2] & ~sy_pin[1];
   wire long_low = (low_cnt >= 32'(RSL_CYC));
   wire osr_chg  = (osr_q != i_oversampling_ratio);
   wire aligned  = (tick_cnt == '0) && (state == ST_CONV);
   wire restart  = (i_chop_enable_bit & (sy_fall | osr_chg)) |
                   (~i_chop_enable_bit & sy_fall & ~aligned);
   wire cmd_stby = spi_evt.cmd_valid & (spi_evt.cmd == CMD_STANDBY);
   wire cmd_wake = spi_evt.cmd_valid & (spi_evt.cmd == CMD_WAKEUP);
   wire seg_end  = mod_tick &
                   (((state == ST_LEAD) && (tick_cnt == lead_len - 1'b1)) ||
                    ((state == ST_SETTLE) && (tick_cnt == settle_len - 1'b1)) ||
                    ((state == ST_CONV) && (tick_cnt == conv_len - 1'b1)));
   wire conv_end = seg_end && (state == ST_CONV);
   wire new_res  = conv_end && (!i_chop_enable_bit || have_first);

   // ------------------------------------------------------------------
   // Chop averaging per channel
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_avg
         logic signed [SAMPLE_W-1:0] raw;
         logic signed [SAMPLE_W-1:0] corr;
         logic signed [SAMPLE_W:0]   sum;
         assign raw  = (g == 0) ? i_filt_data.ch0 : i_filt_data.ch1;
         assign corr = o_chop_polarity ? -raw : raw;
         assign sum  = {corr[SAMPLE_W-1], corr} +
                       ((g == 0) ? {prev.ch0[SAMPLE_W-1], prev.ch0}
                                 : {prev.ch1[SAMPLE_W-1], prev.ch1});
         if (g == 0) begin : g_c0
            assign avg.ch0 = sum[SAMPLE_W:1];
         end else begin : g_c1
            assign avg.ch1 = sum[SAMPLE_W:1];
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            next_state = i_chop_enable_bit ? ST_LEAD : ST_CONV;
         end
         ST_LEAD: begin
            if (seg_end) begin
               next_state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (seg_end) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (conv_end && i_chop_enable_bit) begin
               next_state = ST_SETTLE;
            end
         end
         ST_STBY: begin
            if (cmd_wake) begin
               next_state = ST_IDLE;
            end
         end
         ST_RST: begin
            if (!sy_low) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (state != ST_RST && state != ST_STBY && restart) begin
         next_state = ST_IDLE;
      end
      if (cmd_stby && state != ST_RST) begin
         next_state = ST_STBY;
      end
      if (long_low) begin
         next_state = ST_RST;
      end
   end

   // ------------------------------------------------------------------
   // Sync pin and modulator divider
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         sy_pin  <= 3'h7;
         low_cnt <= '0;
      end else begin
         sy_pin  <= {sy_pin[1:0], i_sync_rst_n};
         if (!sy_low) begin
            low_cnt <= '0;
         end else if (!long_low) begin
            low_cnt <= low_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || mod_tick || state == ST_STBY) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state           <= ST_IDLE;
         tick_cnt        <= '0;
         osr_q           <= '0;
         have_first      <= 1'b0;
         o_chop_polarity <= 1'b0;
         o_filter_rst    <= 1'b1;
      end else begin
         state        <= next_state;
         osr_q        <= i_oversampling_ratio;
         o_filter_rst <= 1'b0;
         if (next_state != state || seg_end) begin
            tick_cnt <= '0;
         end else if (mod_tick) begin
            tick_cnt <= tick_cnt + 1'b1;
         end
         if (next_state == ST_IDLE || next_state == ST_RST ||
             next_state == ST_STBY) begin
            have_first      <= 1'b0;
            o_chop_polarity <= 1'b0;
            o_filter_rst    <= 1'b1;
         end else if (!i_chop_enable_bit && o_chop_polarity) begin
            o_chop_polarity <= 1'b0;
            o_filter_rst    <= 1'b1;
         end else if (conv_end) begin
            have_first <= 1'b1;
            if (i_chop_enable_bit) begin
               o_chop_polarity <= ~o_chop_polarity;
               o_filter_rst    <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Results and ready pin
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         prev     <= '0;
         o_result <= '0;
      end else if (conv_end) begin
         prev <= i_chop_enable_bit ? (o_chop_polarity ?
                 csc_chan_pair_t'({-i_filt_data.ch1, -i_filt_data.ch0}) :
                 i_filt_data) : '0;
         o_result <= i_chop_enable_bit ? avg : i_filt_data;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_conversion_ready_pin_n <= 1'b1;
         conversion_ready_pin_pend                <= 1'b0;
      end else if (new_res) begin
         o_conversion_ready_pin_n <= ~o_conversion_ready_pin_n;
         conversion_ready_pin_pend                <= ~o_conversion_ready_pin_n;
      end else if (conversion_ready_pin_pend) begin
         o_conversion_ready_pin_n <= 1'b0;
         conversion_ready_pin_pend                <= 1'b0;
      end else if (spi_evt.frame_full || state == ST_RST ||
                   state == ST_STBY) begin
         o_conversion_ready_pin_n <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Mode outputs
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_mod_tick       <= 1'b0;
         o_power_level    <= HIGH_RESOLUTION_LEVEL;
         o_test_signal_en <= 1'b0;
         o_standby        <= 1'b0;
         o_channels_on    <= 1'b0;
         o_in_reset       <= 1'b0;
         o_dout           <= 1'b0;
         o_dout_oe        <= 1'b0;
      end else begin
         o_mod_tick       <= mod_tick;
         o_power_level    <= i_power_level_field;
         o_test_signal_en <= i_test_signal_req & ~i_chop_enable_bit;
         o_standby        <= (next_state == ST_STBY);
         o_channels_on    <= (next_state != ST_STBY) &&
                             (next_state != ST_RST);
         o_in_reset       <= (next_state == ST_RST);
         o_dout           <= spi_dout;
         o_dout_oe        <= spi_oe;
      end
   end

   // ------------------------------------------------------------------
   // Serial interface
   // ------------------------------------------------------------------
   csc_spi_shift u_spi (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst | (state == ST_RST)),
      .i_cs_n    (i_cs_n),
      .i_sclk    (i_sclk),
      .i_din     (i_din),
      .i_tx_word ({i_status_word, o_result.ch0, o_result.ch1}),
      .o_dout    (spi_dout),
      .o_dout_oe (spi_oe),
      .o_evt     (spi_evt)
   );

endmodule : csc_conv_ctrl

// ==== csc_conv_ctrl_assertions.sv ====
// Concurrent checks on the top ports of the conversion control block.
// Assumes one reference clock domain, synchronous active-high reset.
`timescale 1ns/1ps
module csc_conv_ctrl_checker #(
   parameter int RSL_CYC = csc_pkg::RSL_CYC
) (
   input wire logic       i_ref_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_chop_enable_bit,
   input wire logic [1:0] i_power_level_field,
   input wire logic       i_sync_rst_n,
   input wire logic       i_cs_n,
   input wire logic       o_dout_oe,
   input wire logic       o_chop_polarity,
   input wire logic       o_filter_rst,
   input wire logic       o_mod_tick,
   input wire logic [1:0] o_power_level,
   input wire logic       o_test_signal_en,
   input wire logic       o_standby,
   input wire logic       o_channels_on,
   input wire logic       o_in_reset
);
   // ------------------------------------------------------------
   // Cycles the sync pin has been low, saturating
   // ------------------------------------------------------------
   logic [15:0] low_cnt;
   logic [15:0] next_low_cnt;
   assign next_low_cnt = (&low_cnt) ? low_cnt : low_cnt + 16'h0001;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || i_sync_rst_n) low_cnt <= 16'h0000;
      else low_cnt <= next_low_cnt;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_chop_sync;
      i_chop_enable_bit && $fell(i_sync_rst_n);
   endsequence
   sequence s_swap;
      $changed(o_chop_polarity);
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_TEST_GATED:
      assert property ($past(i_chop_enable_bit) |-> !o_test_signal_en)
      else $error("test signal enabled in chop mode");
   AST_PWR_COPY:
      assert property (!$past(i_sys_rst) |->
         o_power_level == $past(i_power_level_field))
      else $error("power level does not follow its field");
   AST_TICK_GAP:
      assert property (o_mod_tick |=> !o_mod_tick)
      else $error("modulator ticks back to back");
   AST_STBY_OFF:
      assert property (o_standby |-> !o_channels_on)
      else $error("channels on during standby");
   AST_DOUT_FLOAT:
      assert property (i_cs_n [*8] |-> !o_dout_oe)
      else $error("serial output driven while deselected");
   AST_SYNC_RESTART:
      assert property (s_chop_sync |-> ##[1:8] o_filter_rst)
      else $error("no restart after sync fall in chop mode");
   AST_SWAP_RST:
      assert property (s_swap |->
         (o_filter_rst || $past(o_filter_rst)) or ##1 o_filter_rst)
      else $error("polarity swap without filter reset");
   AST_RST_HOLD:
      assert property (o_in_reset && !i_sync_rst_n |=> o_in_reset)
      else $error("pin reset left while pin still low");
   AST_RST_ENTER:
      assert property (low_cnt == 16'(RSL_CYC + 8) |-> o_in_reset)
      else $error("long sync low did not reset");
endmodule : csc_conv_ctrl_checker

bind csc_conv_ctrl csc_conv_ctrl_checker #(.RSL_CYC(RSL_CYC)) u_chk (
   .i_ref_clk, .i_sys_rst, .i_chop_enable_bit, .i_power_level_field,
   .i_sync_rst_n, .i_cs_n, .o_dout_oe, .o_chop_polarity, .o_filter_rst,
   .o_mod_tick, .o_power_level, .o_test_signal_en, .o_standby,
   .o_channels_on, .o_in_reset);

// ==== csc_host_model.sv ====
// Host controller model: SPI mode 1 frames and sync pin pulses.
// Assumes its clock is the block's reference clock; tasks are called.
`timescale 1ns/1ps
module csc_host_model (
   input  wire logic        i_clk,
   input  wire logic        i_dout,
   output logic             o_cs_n,
   output logic             o_sclk,
   output logic             o_din,
   output logic             o_sync_rst_n,
   output logic [63:0]      o_rx
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_sync_rst_n = 1'b1;
      o_rx = 64'h0;
   end
   // ------------------------------------------------------------
   // One frame, SCLK period 8 clocks, command first, MSB first
   // ------------------------------------------------------------
   task automatic frame(input logic [15:0] cmd, input int nbits);
      @(posedge i_clk) o_cs_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int i = 0; i < nbits; i++) begin
         @(posedge i_clk);
         o_sclk <= 1'b1;
         o_din <= (i < 16) ? cmd[15 - i] : 1'b0;
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b0;
         // Sampled late in the low phase to allow for synchronisers
         repeat (3) @(posedge i_clk);
         o_rx <= {o_rx[62:0], i_dout};
      end
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_din <= ~o_din;
   endtask : frame
   task automatic sync(input int len);
      @(posedge i_clk) o_sync_rst_n <= 1'b0;
      repeat (len) @(posedge i_clk);
      o_sync_rst_n <= 1'b1;
   endtask : sync
endmodule : csc_host_model

// ==== csc_pkg.sv ====
// Shared constants and carrier types for the conversion control block.
// Assumes a 40 MHz reference clock; pin timing is counted in its cycles, sequencing in modulator ticks.
package csc_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int REF_CLK_MHZ  = 40;
   localparam int RSL_TIME_NS  = 50000;
   localparam int RSL_CYC      = (RSL_TIME_NS * REF_CLK_MHZ) / 1000;
   localparam int LEAD_TICKS   = 44;
   localparam int CONV_MULT    = 3;
   localparam int CNT_W        = 18;

   // Reference cycles per modulator period, per power level
   localparam logic [3:0] MOD_DIV_HR  = 4'h2;
   localparam logic [3:0] MOD_DIV_LP  = 4'h4;
   localparam logic [3:0] MOD_DIV_VLP = 4'h8;

   // ------------------------------------------------------------------
   // Power levels
   // ------------------------------------------------------------------
   localparam logic [1:0] HIGH_RESOLUTION_LEVEL = 2'h0;
   localparam logic [1:0] LOW_POWER_LEVEL       = 2'h1;
   localparam logic [1:0] VERY_LOW_POWER_LEVEL  = 2'h2;

   // ------------------------------------------------------------------
   // Serial frame layout and commands
   // ------------------------------------------------------------------
   localparam int CMD_W     = 16;
   localparam int SAMPLE_W  = 24;
   localparam int FRAME_W   = CMD_W + 2 * SAMPLE_W;
   localparam int BITCNT_W  = 7;
   localparam logic [15:0] CMD_STANDBY = 16'h0022;
   localparam logic [15:0] CMD_WAKEUP  = 16'h0033;

   typedef struct packed {
      logic [SAMPLE_W-1:0] ch1;
      logic [SAMPLE_W-1:0] ch0;
   } csc_chan_pair_t;

   typedef struct packed {
      logic             cmd_valid;
      logic [CMD_W-1:0] cmd;
      logic             frame_full;
   } csc_spi_evt_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_LEAD   = 3'b001,
      ST_SETTLE = 3'b011,
      ST_CONV   = 3'b010,
      ST_STBY   = 3'b110,
      ST_RST    = 3'b111
   } csc_state_t;

endpackage : csc_pkg

// ==== csc_spi_shift.sv ====
// SPI mode 1 peripheral shifter for the conversion control block.
// Assumes pins arrive asynchronously; each passes two flip-flops first.
`timescale 1ns/1ps
module csc_spi_shift (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_sys_rst,
   input  wire logic                      i_cs_n,
   input  wire logic                      i_sclk,
   input  wire logic                      i_din,
   input  wire logic [csc_pkg::FRAME_W-1:0] i_tx_word,
   output logic                           o_dout,
   output logic                           o_dout_oe,
   output csc_pkg::csc_spi_evt_t          o_evt
);
   import csc_pkg::*;

   logic [2:0]          cs_sy;
   logic [2:0]          ck_sy;
   logic [1:0]          di_sy;
   logic [FRAME_W-1:0]  tx_sh;
   logic [CMD_W-1:0]    rx_sh;
   logic [CMD_W-1:0]    cmd;
   logic [BITCNT_W-1:0] bit_cnt;

   wire cs_low  = ~cs_sy[1];
   wire cs_fall = cs_sy[2] & ~cs_sy[1];
   wire cs_rise = ~cs_sy[2] & cs_sy[1];
   wire ck_rise = ~ck_sy[2] & ck_sy[1] & cs_low;
   wire ck_fall = ck_sy[2] & ~ck_sy[1] & cs_low;
   wire got_cmd = (bit_cnt >= BITCNT_W'(CMD_W));
   wire got_all = (bit_cnt >= BITCNT_W'(FRAME_W));

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cs_sy <= 3'h7;
         ck_sy <= 3'h0;
         di_sy <= 2'h0;
      end else begin
         cs_sy <= {cs_sy[1:0], i_cs_n};
         ck_sy <= {ck_sy[1:0], i_sclk};
         di_sy <= {di_sy[0], i_din};
      end
   end

   // ------------------------------------------------------------------
   // Shifting
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tx_sh     <= '0;
         rx_sh     <= '0;
         cmd       <= '0;
         bit_cnt   <= '0;
         o_dout    <= 1'b0;
         o_dout_oe <= 1'b0;
         o_evt     <= '0;
      end else begin
         o_dout_oe <= cs_low;
         o_evt     <= '0;
         if (cs_rise) begin
            bit_cnt              <= '0;
            o_evt.cmd_valid      <= got_cmd;
            o_evt.cmd            <= cmd;
            o_evt.frame_full     <= got_all;
         end else if (cs_fall) begin
            tx_sh   <= i_tx_word;
            bit_cnt <= '0;
         end else begin
            if (ck_rise) begin
               o_dout <= tx_sh[FRAME_W-1];
               tx_sh  <= {tx_sh[FRAME_W-2:0], 1'b0};
            end
            if (ck_fall) begin
               rx_sh <= {rx_sh[CMD_W-2:0], di_sy[1]};
               if (!got_all) begin
                  bit_cnt <= bit_cnt + 1'b1;
               end
               if (bit_cnt == BITCNT_W'(CMD_W - 1)) begin
                  cmd <= {rx_sh[CMD_W-2:0], di_sy[1]};
               end
            end
         end
      end
   end

endmodule : csc_spi_shift

// ==== tb.sv ====
// Bench for the conversion control block: timing rows, then commands.
// Assumes the host model drives all pins and the checker is bound.
`timescale 1ns/1ps
module tb;
   import csc_pkg::*;
   typedef struct {
      logic chop; logic [3:0] dly; logic [14:0] oversampling_ratio; logic [1:0] pwr;
      int per; int first;
   } csc_row_t;
   localparam logic [23:0]    OFS = 24'h000100;
   localparam csc_chan_pair_t SIG = 48'h0123450ABCDE;
   localparam csc_chan_pair_t RAW = {SIG.ch1 + OFS, SIG.ch0 + OFS};
   logic           clk, rst, chop, cs_n, sclk, din, sync_n, dout, oe;
   logic           rdy_n, pol, stby, chon, inrst, ten;
   logic [3:0]     dly;
   logic [14:0]    oversampling_ratio;
   logic [1:0]     pwr, plvl;
   logic [63:0]    rx;
   csc_chan_pair_t filt, res;
   int             cyc, mismatches, checked, n, t0, t1;
   csc_row_t       rows [5];
   csc_host_model host (.i_clk(clk), .i_dout(dout), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_din(din), .o_sync_rst_n(sync_n), .o_rx(rx));
   csc_conv_ctrl #(.RSL_CYC(50)) DUT (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_chop_enable_bit(chop), .i_chop_settle_delay_field(dly),
      .i_oversampling_ratio(oversampling_ratio), .i_power_level_field(pwr),
      .i_test_signal_req(1'b1), .i_filt_data(filt),
      .i_status_word(16'hA5C3), .i_sync_rst_n(sync_n), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(oe),
      .o_conversion_ready_pin_n(rdy_n), .o_result(res),
      .o_chop_polarity(pol), .o_filter_rst(), .o_mod_tick(),
      .o_power_level(plvl), .o_test_signal_en(ten), .o_standby(stby),
      .o_channels_on(chon), .o_in_reset(inrst));
   always #12.5 clk = ~clk;
   // Front end with a fixed offset; the signal flips sign with input polarity
   always @(posedge clk)
      filt <= pol ? {OFS - SIG.ch1, OFS - SIG.ch0} : RAW;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic check(input string nm, input logic [63:0] seen,
                        input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wait_fall(output int cnt);
      logic p;
      cnt = 0;
      do begin
         p = rdy_n;
         @(negedge clk);
         cnt++;
      end while (!(p === 1'b1 && rdy_n === 1'b0) && cnt < 4000);
      if (cnt >= 4000) mismatches++;
   endtask : wait_fall
   task automatic wrap_up();
      if (mismatches == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {chop, dly, oversampling_ratio, pwr} = {1'b0, 4'h0, 15'h0007, 2'h0};
      {cyc, mismatches, checked} = '0;
      filt = RAW;
      rows = '{'{1'h1, 4'h0, 15'h0004, 2'h0, 28, 144},
               '{1'h1, 4'h3, 15'h0002, 2'h1, 88, 352},
               '{1'h1, 4'h1, 15'h0003, 2'h3, 26, 140},
               '{1'h0, 4'h0, 15'h0005, 2'h2, 40, 0},
               '{1'h0, 4'h0, 15'h0007, 2'h0, 14, 0}};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // ------------------------------------------------------------
      // Timing rows: restart, first result, steady period, value
      // ------------------------------------------------------------
      foreach (rows[r]) begin
         @(posedge clk);
         {chop, dly, oversampling_ratio, pwr} <= {rows[r].chop, rows[r].dly,
                                   rows[r].oversampling_ratio, rows[r].pwr};
         @(negedge clk);
         t0 = cyc;
         host.sync(4);
         wait_fall(n);
         t1 = cyc - t0;
         // Period taken between two falls that both follow a low pin
         wait_fall(n);
         wait_fall(n);
         check("period", n, rows[r].per);
         if (rows[r].chop)
            check("first", t1 >= rows[r].first &&
                  t1 <= rows[r].first + 16, 1'h1);
         check("result", res, rows[r].chop ? SIG : RAW);
         check("level", plvl, rows[r].pwr);
         check("test", ten, !rows[r].chop);
      end
      // ------------------------------------------------------------
      // Standby, short frame, wakeup, pin reset
      // ------------------------------------------------------------
      host.frame(CMD_STANDBY, 64);
      repeat (100) @(negedge clk);
      check("frame", rx, {16'hA5C3, RAW.ch0, RAW.ch1});
      check("standby", {stby, chon, rdy_n}, 3'h5);
      host.frame(CMD_WAKEUP, 8);
      repeat (8) @(negedge clk);
      check("short", stby, 1'h1);
      host.frame(CMD_WAKEUP, 64);
      repeat (8) @(negedge clk);
      check("wake", stby, 1'h0);
      wait_fall(n);
      check("chan", chon, 1'h1);
      fork
         host.sync(70);
         begin
            repeat (66) @(negedge clk);
            check("in_reset", inrst, 1'h1);
         end
      join
      repeat (8) @(negedge clk);
      check("out_reset", inrst, 1'h0);
      wait_fall(n);
      wait_fall(n);
      wait_fall(n);
      check("resume", n, 14);
      wrap_up();
   end
endmodule : tb
